// file: include/axis_torque_monitor_accel_change_params.svh
`ifndef AXIS_TORQUE_MONITOR_ACCEL_CHANGE_PARAMS_SVH
`define AXIS_TORQUE_MONITOR_ACCEL_CHANGE_PARAMS_SVH

// Number of axes served by one block
`define ATM_NUM_AXES 4

// Torque limits in 0.1 percent units
`define ATM_TL_DEFAULT 16'h0BB8
`define ATM_TL_MIN 16'h0001
`define ATM_TL_MAX 16'h2710

// Divisor from 0.1 percent to 1 percent units
`define ATM_STORE_DIV 16'h000A

// A new time of zero keeps the present time
`define ATM_TIME_KEEP 16'h0000

// Reset values of the present acceleration and deceleration times
`define ATM_ACCEL_RESET 16'h0000
`define ATM_DECEL_RESET 16'h0000

`endif

// file: include/axis_torque_monitor_accel_change_pkg.sv
package axis_torque_monitor_accel_change_pkg;

  // Torque limit pair, both in 0.1 percent units
  typedef struct packed {
    logic [15:0] pos;
    logic [15:0] neg;
  } torque_pair_t;

  // Acceleration and deceleration times in milliseconds
  typedef struct packed {
    logic [15:0] accel;
    logic [15:0] decel;
  } accdec_t;

  // Speed change command towards the axis profile generator
  typedef struct packed {
    logic [31:0] speed;
    accdec_t     times;
  } speed_cmd_t;

  // Which indirect sources are configured for an axis
  typedef struct packed {
    logic enable_cfg;
    logic accel_cfg;
    logic decel_cfg;
  } change_cfg_t;

  typedef enum logic [0:0] {
    SC_IDLE,
    SC_ISSUE
  } sc_state_t;

endpackage

// file: hdl/axis_torque_monitor_accel_change.sv
// What this block does
// - Each axis has separate positive and negative torque limit monitors spanning 0.1 to 1000.0 percent.
// - The positive monitor holds the counter_clockwise driving limit, also the clockwise regenerative limit.
// - The negative monitor holds the clockwise driving limit, also the counter_clockwise regenerative limit.
// - When the amplifier powers on, both torque limits are loaded with 300.0 percent; the monitors take it at the next operation cycle.
// - The positive limit alone is copied in 1 percent units into the axis torque limit store.
// - Time replacement happens only as part of a speed change.
// - With the enable bit set, a speed change uses the supplied new times.
// - With the enable bit clear, a speed change keeps the present times.
// - A new acceleration time of zero keeps the present acceleration time.
// - With enable set, a new acceleration time of 1 to 65535 ms replaces the present one.
// - A new deceleration time of zero keeps the present deceleration time.
// - With enable set, a new deceleration time of 1 to 65535 ms replaces the present one.
// - An axis with no enable source configured never changes its times on a speed change.
// - An unconfigured new acceleration or deceleration source leaves that time unchanged.
// - Both monitor words are refreshed once each operation cycle.
// - Enable and new times are sampled only when a speed change request is accepted.
`include "axis_torque_monitor_accel_change_params.svh"
`timescale 1ns/100ps
`default_nettype none

module axis_torque_monitor_accel_change (
  input  wire logic                                                   ref_clk,
  input  wire logic                                                   sys_rst,
  input  wire logic                                                   clk_en,
  input  wire logic                                                   op_cycle_tick,
  input  wire logic [`ATM_NUM_AXES-1:0]                               amp_powered,
  input  wire logic [`ATM_NUM_AXES-1:0]                               torque_set,
  input  wire axis_torque_monitor_accel_change_pkg::torque_pair_t [`ATM_NUM_AXES-1:0] torque_set_value,
  input  wire logic [`ATM_NUM_AXES-1:0]                               motion_start,
  input  wire axis_torque_monitor_accel_change_pkg::accdec_t [`ATM_NUM_AXES-1:0] start_times,
  input  wire axis_torque_monitor_accel_change_pkg::change_cfg_t [`ATM_NUM_AXES-1:0] change_cfg,
  input  wire logic [`ATM_NUM_AXES-1:0]                               time_change_enable,
  input  wire axis_torque_monitor_accel_change_pkg::accdec_t [`ATM_NUM_AXES-1:0] new_times,
  input  wire logic [`ATM_NUM_AXES-1:0]                               speed_change_request,
  input  wire logic [`ATM_NUM_AXES-1:0][31:0]                         speed_change_value,
  input  wire logic [`ATM_NUM_AXES-1:0]                               speed_cmd_ready,
  output var  axis_torque_monitor_accel_change_pkg::torque_pair_t [`ATM_NUM_AXES-1:0] amp_torque_limit,
  output var  axis_torque_monitor_accel_change_pkg::torque_pair_t [`ATM_NUM_AXES-1:0] torque_monitor,
  output var  logic [`ATM_NUM_AXES-1:0][15:0]                         axis_torque_limit_store,
  output var  axis_torque_monitor_accel_change_pkg::accdec_t [`ATM_NUM_AXES-1:0] present_times,
  output var  logic [`ATM_NUM_AXES-1:0]                               speed_cmd_valid,
  output var  axis_torque_monitor_accel_change_pkg::speed_cmd_t [`ATM_NUM_AXES-1:0] speed_cmd,
  output var  logic [`ATM_NUM_AXES-1:0]                               speed_change_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Keep a commanded limit inside 0.1 .. 1000.0 percent
  function automatic logic [15:0] clamp_limit(input logic [15:0] value);
    logic [15:0] result;
    result = value;
    if (value < `ATM_TL_MIN) begin
      result = `ATM_TL_MIN;
    end else if (value > `ATM_TL_MAX) begin
      result = `ATM_TL_MAX;
    end
    return result;
  endfunction

  // Pick the time a speed change will use
  function automatic logic [15:0] pick_time(input logic        enabled,
                                            input logic        src_cfg,
                                            input logic [15:0] new_time,
                                            input logic [15:0] cur_time);
    logic [15:0] result;
    result = cur_time;
    if (enabled && src_cfg && (new_time != `ATM_TIME_KEEP)) begin
      result = new_time;
    end
    return result;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // One slice per axis

  genvar ax;
  generate
    for (ax = 0; ax < `ATM_NUM_AXES; ax = ax + 1) begin : g_axis

      //////////////////////////////////////////////////////////////////////
      // Torque limit path

      axis_torque_monitor_accel_change_pkg::torque_pair_t limit;
      axis_torque_monitor_accel_change_pkg::torque_pair_t next_limit;
      axis_torque_monitor_accel_change_pkg::torque_pair_t monitor;
      axis_torque_monitor_accel_change_pkg::torque_pair_t next_monitor;
      logic [15:0] store;
      logic [15:0] next_store;
      logic        powered_q;
      logic        next_powered_q;
      logic        power_rise;

      assign power_rise = amp_powered[ax] & ~powered_q;

      always_comb begin
        next_powered_q = amp_powered[ax];
        next_limit     = limit;
        next_monitor   = monitor;
        next_store     = store;
        // Power-on default overrides a same-cycle set
        if (power_rise) begin
          next_limit.pos = `ATM_TL_DEFAULT;
          next_limit.neg = `ATM_TL_DEFAULT;
        end else if (torque_set[ax]) begin
          next_limit.pos = clamp_limit(torque_set_value[ax].pos);
          next_limit.neg = clamp_limit(torque_set_value[ax].neg);
        end
        // Monitor words follow the command once per cycle, not every clock
        if (op_cycle_tick) begin
          next_monitor.pos = limit.pos;
          next_monitor.neg = limit.neg;
          // Truncating divide; the negative limit is never stored
          next_store = 16'(limit.pos / `ATM_STORE_DIV);
        end
      end

      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          powered_q   <= 1'b0;
          limit.pos   <= `ATM_TL_DEFAULT;
          limit.neg   <= `ATM_TL_DEFAULT;
          monitor.pos <= `ATM_TL_DEFAULT;
          monitor.neg <= `ATM_TL_DEFAULT;
          store       <= 16'(`ATM_TL_DEFAULT / `ATM_STORE_DIV);
        end else if (clk_en) begin
          powered_q <= next_powered_q;
          limit     <= next_limit;
          monitor   <= next_monitor;
          store     <= next_store;
        end
      end

      assign amp_torque_limit[ax]        = limit;
      assign torque_monitor[ax]          = monitor;
      assign axis_torque_limit_store[ax] = store;

      //////////////////////////////////////////////////////////////////////
      // Speed change with optional time replacement

      axis_torque_monitor_accel_change_pkg::sc_state_t  state;
      axis_torque_monitor_accel_change_pkg::sc_state_t  next_state;
      axis_torque_monitor_accel_change_pkg::accdec_t    cur;
      axis_torque_monitor_accel_change_pkg::accdec_t    next_cur;
      axis_torque_monitor_accel_change_pkg::speed_cmd_t cmd;
      axis_torque_monitor_accel_change_pkg::speed_cmd_t next_cmd;
      logic enabled;
      logic accept;

      // No enable source means the enable bit reads as off forever
      assign enabled = change_cfg[ax].enable_cfg & time_change_enable[ax];
      assign accept  = (state == axis_torque_monitor_accel_change_pkg::SC_IDLE)
                       & speed_change_request[ax];

      always_comb begin
        next_state = state;
        next_cur   = cur;
        next_cmd   = cmd;
        case (state)
          axis_torque_monitor_accel_change_pkg::SC_IDLE: begin
            // A new positioning start reloads the present times, unless a request is accepted in the same cycle
            if (motion_start[ax]) begin
              next_cur = start_times[ax];
            end
            // Sources are looked at only here, on acceptance
            if (accept) begin
              next_cmd.speed = speed_change_value[ax];
              next_cmd.times.accel = pick_time(enabled, change_cfg[ax].accel_cfg,
                                               new_times[ax].accel,
                                               cur.accel);
              next_cmd.times.decel = pick_time(enabled, change_cfg[ax].decel_cfg,
                                               new_times[ax].decel,
                                               cur.decel);
              next_cur   = next_cmd.times;
              next_state = axis_torque_monitor_accel_change_pkg::SC_ISSUE;
            end
          end
          axis_torque_monitor_accel_change_pkg::SC_ISSUE: begin
            // Requests are dropped here; the busy flag shows it
            if (speed_cmd_ready[ax]) begin
              next_state = axis_torque_monitor_accel_change_pkg::SC_IDLE;
            end
          end
          default: begin
            next_state = axis_torque_monitor_accel_change_pkg::SC_IDLE;
          end
        endcase
      end

      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          state           <= axis_torque_monitor_accel_change_pkg::SC_IDLE;
          cur.accel       <= `ATM_ACCEL_RESET;
          cur.decel       <= `ATM_DECEL_RESET;
          cmd.speed       <= 32'h0000_0000;
          cmd.times.accel <= `ATM_ACCEL_RESET;
          cmd.times.decel <= `ATM_DECEL_RESET;
        end else if (clk_en) begin
          state <= next_state;
          cur   <= next_cur;
          cmd   <= next_cmd;
        end
      end

      assign present_times[ax]     = cur;
      assign speed_cmd[ax]         = cmd;
      assign speed_cmd_valid[ax]   = (state == axis_torque_monitor_accel_change_pkg::SC_ISSUE);
      assign speed_change_busy[ax] = (state == axis_torque_monitor_accel_change_pkg::SC_ISSUE);

    end
  endgenerate

endmodule

`default_nettype wire

// file: sim/axis_torque_monitor_accel_change_props.sv
`timescale 1ns/100ps
`default_nettype none
module atm_props (
  input wire logic       ref_clk,
  input wire logic       sys_rst,
  input wire logic       clk_en,
  input wire logic       op_cycle_tick,
  input wire logic [3:0] amp_powered,
  input wire logic [3:0] torque_set,
  input wire logic [3:0] motion_start,
  input wire logic [3:0] time_change_enable,
  input wire logic [3:0] speed_change_request,
  input wire logic [3:0] speed_cmd_ready,
  input wire logic [3:0] speed_cmd_valid,
  input wire logic [3:0] speed_change_busy,
  input wire logic [3:0][15:0] axis_torque_limit_store,
  input wire axis_torque_monitor_accel_change_pkg::torque_pair_t [3:0] torque_set_value,
  input wire axis_torque_monitor_accel_change_pkg::torque_pair_t [3:0] amp_torque_limit,
  input wire axis_torque_monitor_accel_change_pkg::torque_pair_t [3:0] torque_monitor,
  input wire axis_torque_monitor_accel_change_pkg::change_cfg_t [3:0] change_cfg,
  input wire axis_torque_monitor_accel_change_pkg::accdec_t [3:0] new_times,
  input wire axis_torque_monitor_accel_change_pkg::accdec_t [3:0] present_times,
  input wire axis_torque_monitor_accel_change_pkg::speed_cmd_t [3:0] speed_cmd
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst || !clk_en);
  // Axis 0 only; every axis is an identical generated slice
  wire take = change_cfg[0].enable_cfg && time_change_enable[0];
  wire [15:0] exp_acc = (take && change_cfg[0].accel_cfg && |new_times[0].accel)
    ? new_times[0].accel : present_times[0].accel;
  wire [15:0] exp_dec = (take && change_cfg[0].decel_cfg && |new_times[0].decel)
    ? new_times[0].decel : present_times[0].decel;
  wire [31:0] exp_t = {exp_acc, exp_dec};
  // Clamped values would not echo, so only legal values are traced
  wire ok_val = torque_set_value[0].pos inside {[16'h0001:16'h2710]}
    && torque_set_value[0].neg inside {[16'h0001:16'h2710]};
  sequence accepted;
    speed_change_request[0] && !speed_change_busy[0] && !motion_start[0];
  endsequence
  sequence served;
    speed_cmd_valid[0] && speed_cmd_ready[0];
  endsequence
  def_load_a: assert property ($rose(amp_powered[0]) |=>
    amp_torque_limit[0] == {16'h0BB8, 16'h0BB8}) else $error("no default after power rise");
  set_limit_a: assert property (torque_set[0] && ok_val && !$rose(amp_powered[0])
    && !$past(sys_rst) |=> amp_torque_limit[0] == $past(torque_set_value[0])) else $error("limit");
  mon_refresh_a: assert property (op_cycle_tick |=>
    torque_monitor[0] == $past(amp_torque_limit[0])) else $error("monitor not refreshed");
  store_copy_a: assert property (op_cycle_tick |=>
    axis_torque_limit_store[0] == $past(amp_torque_limit[0].pos) / 16'h000A) else $error("store");
  time_pick_a: assert property (accepted |=> speed_cmd_valid[0]
    && speed_cmd[0].times == $past(exp_t) && present_times[0] == $past(exp_t)) else $error("times");
  cmd_hold_a: assert property (speed_cmd_valid[0] && !speed_cmd_ready[0] |=>
    speed_cmd_valid[0] && $stable(speed_cmd[0])) else $error("command dropped early");
  cmd_done_a: assert property (served |=>
    !speed_cmd_valid[0] && !speed_change_busy[0]) else $error("command not released");
  times_keep_a: assert property (speed_change_busy[0]
    || !speed_change_request[0] && !motion_start[0] |=> $stable(present_times[0])) else $error("kp");
endmodule
bind axis_torque_monitor_accel_change atm_props u_props (.*);
`default_nettype wire

// file: sim/servo_amp_model.sv
`timescale 1ns/100ps
`default_nettype none
module servo_amp_model (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       slow,
  input  wire logic [3:0] speed_cmd_valid,
  output var  logic [3:0] speed_cmd_ready
);
  logic [3:0][1:0] wait_cnt;
  logic [3:0][1:0] next_wait_cnt;
  // Slow mode holds off acceptance for three cycles
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      next_wait_cnt[i] = speed_cmd_valid[i] ? wait_cnt[i] + 2'h1 : 2'h0;
      speed_cmd_ready[i] = speed_cmd_valid[i] && (!slow || wait_cnt[i] == 2'h3);
    end
  end
  always_ff @(posedge ref_clk) begin
    wait_cnt <= sys_rst ? '0 : next_wait_cnt;
  end
endmodule
`default_nettype wire

// file: sim/axis_torque_monitor_accel_change_tb.sv
`timescale 1ns/100ps
`default_nettype none
module axis_torque_monitor_accel_change_tb;
  logic ref_clk, sys_rst, clk_en, op_cycle_tick, slow;
  logic [3:0] amp_powered, torque_set, motion_start, time_change_enable;
  logic [3:0] speed_change_request, speed_cmd_ready, speed_cmd_valid, speed_change_busy;
  logic [3:0][31:0] speed_change_value;
  logic [3:0][15:0] axis_torque_limit_store;
  axis_torque_monitor_accel_change_pkg::torque_pair_t [3:0] torque_set_value, amp_torque_limit;
  axis_torque_monitor_accel_change_pkg::torque_pair_t [3:0] torque_monitor;
  axis_torque_monitor_accel_change_pkg::accdec_t [3:0] start_times, new_times, present_times;
  axis_torque_monitor_accel_change_pkg::change_cfg_t [3:0] change_cfg;
  axis_torque_monitor_accel_change_pkg::speed_cmd_t [3:0] speed_cmd;
  logic [31:0] seed = 32'h0000_0d4f;
  logic [31:0] r, v, nt, st, e;
  logic [2:0] cf;
  int a, n, w, fails, checks_done, cycles;
  axis_torque_monitor_accel_change uut (.*);
  servo_amp_model amp (.*);
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [15:0] lim(input int k);
    logic [31:0] x;
    x = rnd();
    return (k == 0) ? 16'h0001 : (k == 1) ? 16'h2710 : 16'h0001 + 16'(x % 32'h0000_2710);
  endfunction
  function automatic logic [31:0] pick(input logic [2:0] c, input logic en, input logic [31:0] t, u);
    pick = u;
    if (c[2] && en && c[1] && t[31:16] != 16'h0000) pick[31:16] = t[31:16];
    if (c[2] && en && c[0] && t[15:0] != 16'h0000) pick[15:0] = t[15:0];
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    if (fails == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic load(input int x, input logic pw, input logic [31:0] val);
    @(posedge ref_clk);
    amp_powered[x] <= pw;
    torque_set[x] <= 1'b1;
    torque_set_value[x] <= val;
    @(posedge ref_clk);
    torque_set[x] <= 1'b0;
    op_cycle_tick <= 1'b1;
    @(posedge ref_clk);
    op_cycle_tick <= 1'b0;
    #1;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails++;
      conclude();
    end
  end
  initial begin
    {sys_rst, clk_en, op_cycle_tick, slow, amp_powered, torque_set} = 12'hC00;
    {motion_start, time_change_enable, speed_change_request, speed_change_value} = '0;
    {torque_set_value, start_times, new_times, change_cfg} = '0;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    for (n = 0; n < 4; n++) begin
      check(torque_monitor[n], 32'h0BB8_0BB8);
      check(axis_torque_limit_store[n], 32'h0000_012C);
    end
    for (n = 0; n < 30; n++) begin
      a = rnd() % 4;
      v = {lim(n), lim(n + 1)};
      load(a, 1'b0, v);
      check(torque_monitor[a], v);
      check(axis_torque_limit_store[a], v[31:16] / 16'h000A);
    end
    // Power rise beats a set in the same cycle
    for (n = 0; n < 4; n++) begin
      load(n, 1'b1, rnd());
      check(torque_monitor[n], 32'h0BB8_0BB8);
    end
    // Out-of-range commands land on the span ends
    load(0, 1'b1, 32'h0000_FFFF);
    check(torque_monitor[0], 32'h0001_2710);
    for (n = 0; n < 40; n++) begin
      a = rnd() % 4;
      r = rnd();
      st = rnd();
      cf = (n < 8) ? n[2:0] : r[2:0];
      nt = {r[4] ? 16'h0000 : r[31:16], r[5] ? 16'h0000 : r[15:0]};
      e = pick(cf, n < 8 || r[3], nt, st);
      @(posedge ref_clk);
      slow <= r[6];
      motion_start[a] <= 1'b1;
      start_times[a] <= st;
      @(posedge ref_clk);
      motion_start[a] <= 1'b0;
      change_cfg[a] <= cf;
      time_change_enable[a] <= n < 8 || r[3];
      new_times[a] <= nt;
      speed_change_value[a] <= r;
      speed_change_request[a] <= 1'b1;
      // Inputs move after acceptance; request stays up for the first busy cycle only
      @(posedge ref_clk);
      new_times[a] <= ~nt;
      time_change_enable[a] <= ~time_change_enable[a];
      #1;
      check(speed_cmd_valid[a], 32'h0000_0001);
      check(speed_cmd[a].times, e);
      check(speed_cmd[a].speed, r);
      @(posedge ref_clk);
      speed_change_request[a] <= 1'b0;
      #1;
      for (w = 0; w < 8 && speed_cmd_valid[a] !== 1'b0; w++) begin
        @(posedge ref_clk);
        #1;
      end
      check(speed_cmd_valid[a], 32'h0000_0000);
      check(present_times[a], e);
    end
    conclude();
  end
endmodule
`default_nettype wire
